// file: include/ddps_pkg.sv
// Package of constants and types for the dual data pointer select block
//
// Overview of operation
// - Two independent 16-bit data pointers for external memory
// - Aux register bit 0 selects the active pointer
// - Selector 0 uses pointer zero, 1 pointer one
// - Bit 3 is a plain read/write user flag
// - Reset clears selector and bit 3; bit 2 reads zero
// - Reserved bits read back as zero
// - Reserved functions reset to zero, active at one
// - Increment of aux register toggles selector bit
`default_nettype none
package ddps_pkg;
  // Special function register address of the auxiliary register
  localparam logic [7:0] DDPS_AUX_ADDR   = 8'ha2;
  // Field positions
  localparam int         DDPS_SEL_BIT    = 0;
  localparam int         DDPS_ZERO_BIT   = 2;
  localparam int         DDPS_FLAG_BIT   = 3;
  // Reset values
  localparam logic [7:0] DDPS_AUX_RESET  = 8'h00;
  localparam logic [15:0] DDPS_PTR_RESET = 16'h0000;
  // Writable bits of the auxiliary register; reserved bits read as zero
  localparam logic [7:0] DDPS_AUX_MASK   = 8'h09;
  // Pointer operations requested by the core
  typedef enum logic [1:0] {
    DDPS_OP_NONE,
    DDPS_OP_LOAD,
    DDPS_OP_INC
  } ddps_op_t;
endpackage : ddps_pkg
`default_nettype wire

// file: rtl/ddps_pointer.sv
// One 16-bit data pointer with load and increment
`default_nettype none
module ddps_pointer (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Control
  input  wire logic              enable,
  input  wire ddps_pkg::ddps_op_t op,
  input  wire logic [15:0]       load_value,
  // Contents
  output logic      [15:0]       value
);
  typedef struct packed {
    logic [15:0] ptr;
  } ddps_ptr_state_t;

  ddps_ptr_state_t state;
  ddps_ptr_state_t next_state;

  // Only the enabled pointer moves; the other holds
  always_comb begin
    next_state = state;
    if (enable) begin
      case (op)
        ddps_pkg::DDPS_OP_LOAD: next_state.ptr = load_value;
        ddps_pkg::DDPS_OP_INC:  next_state.ptr = state.ptr + 16'h0001;
        default:                next_state.ptr = state.ptr;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state.ptr <= ddps_pkg::DDPS_PTR_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign value = state.ptr;
endmodule : ddps_pointer
`default_nettype wire

// file: rtl/ddps_top.sv
// Dual data pointer registers with the auxiliary selector register
`default_nettype none
module ddps_top (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Special function register access, whole byte only
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_write,
  input  wire logic [7:0]        sfr_wdata,
  input  wire logic              sfr_inc,
  output logic      [7:0]        sfr_rdata,
  output logic                   sfr_hit,
  // Pointer operations from instruction execution
  input  wire ddps_pkg::ddps_op_t ptr_op,
  input  wire logic [15:0]       ptr_load_value,
  // Pointer outputs
  output logic      [15:0]       data_pointer,
  output logic      [15:0]       data_pointer_zero,
  output logic      [15:0]       data_pointer_one,
  output logic                   pointer_select,
  output logic                   user_flag_three
);
  ////////////////////////////////////////////////////////////////////////////
  // Auxiliary register state
  typedef struct packed {
    logic sel;
    logic flag;
  } ddps_aux_state_t;

  ddps_aux_state_t state;
  ddps_aux_state_t next_state;
  logic            aux_hit;
  logic [15:0]     ptr_val [2];

  // Read image of the register; positions outside selector and flag stay 0
  function automatic logic [7:0] ddps_read_image(input logic sel, input logic flag);
    logic [7:0] image;
    image = 8'h00;
    image[ddps_pkg::DDPS_SEL_BIT]  = sel;
    image[ddps_pkg::DDPS_FLAG_BIT] = flag;
    return image;
  endfunction : ddps_read_image

  assign aux_hit = (sfr_addr == ddps_pkg::DDPS_AUX_ADDR);

  // Byte write stores selector and flag; increment toggles selector only.
  // Reserved writes are dropped, so no reserved function can be enabled.
  always_comb begin
    next_state = state;
    if (aux_hit && sfr_write) begin
      next_state.sel  = sfr_wdata[ddps_pkg::DDPS_SEL_BIT];
      next_state.flag = sfr_wdata[ddps_pkg::DDPS_FLAG_BIT];
    end else if (aux_hit && sfr_inc) begin
      next_state.sel  = ~state.sel;
    end
  end

  // Reset clears selector and flag
  always_ff @(posedge clk) begin
    if (reset) begin
      state.sel  <= ddps_pkg::DDPS_AUX_RESET[ddps_pkg::DDPS_SEL_BIT];
      state.flag <= ddps_pkg::DDPS_AUX_RESET[ddps_pkg::DDPS_FLAG_BIT];
    end else begin
      state <= next_state;
    end
  end

  // Read data: bit 2 and reserved bits return zero
  always_comb begin
    sfr_rdata = 8'h00;
    if (aux_hit) begin
      sfr_rdata = ddps_read_image(state.sel, state.flag);
    end
  end
  assign sfr_hit = aux_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer pair; the registered selector is used, so a change made by one
  // instruction steers the next pointer instruction
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    ddps_pointer u_ptr (
      .clk        (clk),
      .reset      (reset),
      .enable     (state.sel == 1'(i)),
      .op         (ptr_op),
      .load_value (ptr_load_value),
      .value      (ptr_val[i])
    );
  end

  assign data_pointer_zero = ptr_val[0];
  assign data_pointer_one  = ptr_val[1];
  assign data_pointer      = state.sel ? ptr_val[1] : ptr_val[0];
  assign pointer_select    = state.sel;
  assign user_flag_three   = state.flag;

  ////////////////////////////////////////////////////////////////////////////
  // Checks; every property samples on the core clock and sleeps in reset
  default clocking ddps_cb @(posedge clk); endclocking
  default disable iff (reset);

  // Byte write to the auxiliary register
  sequence aux_write_seq;
    aux_hit && sfr_write;
  endsequence

  // Increment of the auxiliary register that no write overrides
  sequence inc_seq;
    aux_hit && sfr_inc && !sfr_write;
  endsequence

  // Cycle in which the auxiliary register is left alone
  sequence aux_quiet_seq;
    !(aux_hit && (sfr_write || sfr_inc));
  endsequence

  // Cycle with no pointer operation
  sequence ptr_idle_seq;
    ptr_op == ddps_pkg::DDPS_OP_NONE;
  endsequence

  // Pointer increment while the selector cannot move
  sequence inc_alone_seq;
    ptr_op == ddps_pkg::DDPS_OP_INC && !(aux_hit && (sfr_write || sfr_inc));
  endsequence

  // Increment toggles rather than forces the selector
  select_toggle_a: assert property (
    inc_seq |=> pointer_select != $past(pointer_select))
    else $error("selector did not toggle on increment");

  // Byte write loads the selector from bit 0
  write_select_a: assert property (
    aux_write_seq |=> pointer_select == $past(sfr_wdata[ddps_pkg::DDPS_SEL_BIT]))
    else $error("selector not written from bit 0");

  // Byte write loads the user flag from bit 3
  flag_write_a: assert property (
    aux_write_seq |=> user_flag_three == $past(sfr_wdata[ddps_pkg::DDPS_FLAG_BIT]))
    else $error("user flag not written from bit 3");

  // Bit 2 is stuck at zero
  zero_bit_a: assert property (
    sfr_rdata[ddps_pkg::DDPS_ZERO_BIT] == 1'b0)
    else $error("bit 2 read as one");

  // Active pointer follows the selector
  mux_out_a: assert property (
    data_pointer == (pointer_select ? data_pointer_one : data_pointer_zero))
    else $error("active pointer mismatch");

  // Pointer zero sleeps while pointer one is selected
  hold_zero_a: assert property (
    pointer_select |=> data_pointer_zero == $past(data_pointer_zero))
    else $error("unselected pointer zero changed");

  // Pointer one sleeps while pointer zero is selected
  hold_one_a: assert property (
    !pointer_select |=> data_pointer_one == $past(data_pointer_one))
    else $error("unselected pointer one changed");

  // A load reaches the active pointer unless the selector moved with it
  load_ptr_a: assert property (
    ptr_op == ddps_pkg::DDPS_OP_LOAD |=>
      data_pointer == $past(ptr_load_value) || pointer_select != $past(pointer_select))
    else $error("load did not reach active pointer");

  // Increment adds one to the active pointer
  inc_ptr_a: assert property (
    inc_alone_seq |=> data_pointer == $past(data_pointer) + 16'h0001)
    else $error("increment wrong");

  // Register leaves reset cleared
  reset_clear_a: assert property (
    $fell(reset) |-> !pointer_select && !user_flag_three)
    else $error("reset did not clear register");

  // Selector holds while the register is not touched
  quiet_keep_a: assert property (
    aux_quiet_seq |=> pointer_select == $past(pointer_select))
    else $error("selector moved without a request");

  // Increment leaves the user flag alone
  flag_keep_a: assert property (
    inc_seq |=> user_flag_three == $past(user_flag_three))
    else $error("increment changed the user flag");

  // Reserved positions read inactive, so no future function wakes up
  reserved_zero_a: assert property (
    sfr_rdata[7:4] == 4'h0 && sfr_rdata[1] == 1'b0)
    else $error("reserved bit read as one");

  // Other addresses read nothing from this block
  miss_read_a: assert property (
    !aux_hit |-> sfr_rdata == 8'h00)
    else $error("read data on foreign address");

  // No pointer operation, no pointer change
  idle_hold_a: assert property (
    ptr_idle_seq |=> data_pointer_zero == $past(data_pointer_zero) &&
      data_pointer_one == $past(data_pointer_one))
    else $error("pointer changed while idle");

  // Load with selector 0 lands in pointer zero
  load_zero_a: assert property (
    ptr_op == ddps_pkg::DDPS_OP_LOAD && !pointer_select |=>
      data_pointer_zero == $past(ptr_load_value))
    else $error("load missed pointer zero");

  // Load with selector 1 lands in pointer one
  load_one_a: assert property (
    ptr_op == ddps_pkg::DDPS_OP_LOAD && pointer_select |=>
      data_pointer_one == $past(ptr_load_value))
    else $error("load missed pointer one");

  // Selector is visible in bit 0 of the read data
  sel_read_a: assert property (
    aux_hit |-> sfr_rdata[ddps_pkg::DDPS_SEL_BIT] == pointer_select)
    else $error("selector read back wrong");

  // User flag is visible in bit 3 of the read data
  flag_read_a: assert property (
    aux_hit |-> sfr_rdata[ddps_pkg::DDPS_FLAG_BIT] == user_flag_three)
    else $error("user flag read back wrong");
endmodule : ddps_top
`default_nettype wire

// file: testbench/ddps_xmem_model.sv
// External data memory model read through the selected pointer
`default_nettype none
module ddps_xmem_model (
  // Address from the selected pointer
  input  wire logic [15:0] addr,
  // Read data
  output logic      [7:0]  rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Data is a fixed function of the address so every read can be predicted
  assign rdata = addr[15:8] ^ addr[7:0];
endmodule : ddps_xmem_model
`default_nettype wire

// file: testbench/ddps_top_tb.sv
// Self-checking bench for the dual data pointer select block
`default_nettype none
module ddps_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk = 1'b0, reset = 1'b1, sfr_write = 1'b0, sfr_inc = 1'b0;
  logic [7:0]         sfr_addr = 8'ha2, sfr_wdata = 8'h00, sfr_rdata, mem_data;
  logic [15:0]        ptr_load_value = 16'h0000, dp, dp0, dp1;
  logic               sel, flag, hit;
  ddps_pkg::ddps_op_t ptr_op = ddps_pkg::DDPS_OP_NONE;
  int                 n_mismatch = 0, tests_run = 0, cycles = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  ddps_top dut (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
    .sfr_wdata(sfr_wdata), .sfr_inc(sfr_inc), .sfr_rdata(sfr_rdata), .sfr_hit(hit),
    .ptr_op(ptr_op), .ptr_load_value(ptr_load_value), .data_pointer(dp),
    .data_pointer_zero(dp0), .data_pointer_one(dp1), .pointer_select(sel),
    .user_flag_three(flag));
  ddps_xmem_model xmem (.addr(dp), .rdata(mem_data));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  // Hang guard: the tests need well under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      test_done;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check
  // One request held for one edge, then idle; outputs settled on return
  task automatic step(input logic w, input logic i, input logic [7:0] d,
                      input ddps_pkg::ddps_op_t op, input logic [15:0] v);
    @(posedge clk);
    sfr_write <= w;
    sfr_inc <= i;
    sfr_wdata <= d;
    ptr_op <= op;
    ptr_load_value <= v;
    @(posedge clk);
    sfr_write <= 1'b0;
    sfr_inc <= 1'b0;
    ptr_op <= ddps_pkg::DDPS_OP_NONE;
    #1;
  endtask : step
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    #1;
    check(16'(hit), 16'h1, "aux decode");
    check(16'(sfr_rdata & 8'h0d), 16'h0, "aux reset");
    check(dp0 | dp1, 16'h0, "pointer reset");
    $display("reset test done");
  endtask : t_reset
  // Flag and selector written as a byte; reserved bits masked off on read
  task automatic t_flag;
    step(1'b1, 1'b0, 8'h09, ddps_pkg::DDPS_OP_NONE, 16'h0);
    check(16'(sfr_rdata & 8'h0d), 16'h0009, "aux readback");
    check(16'({flag, sel}), 16'h3, "flag and select");
    step(1'b1, 1'b1, 8'h00, ddps_pkg::DDPS_OP_NONE, 16'h0);
    check(16'({flag, sel}), 16'h0, "write over inc");
    $display("flag test done");
  endtask : t_flag
  // Load, toggle and increment across both pointers
  task automatic t_swap;
    step(1'b0, 1'b0, 8'h00, ddps_pkg::DDPS_OP_LOAD, 16'h1234);
    check(dp, 16'h1234, "load zero");
    check(16'(mem_data), 16'h0026, "memory read");
    step(1'b0, 1'b1, 8'h00, ddps_pkg::DDPS_OP_LOAD, 16'habcd);
    check(dp0, 16'habcd, "old select used");
    check(16'(sel), 16'h1, "inc toggles");
    step(1'b0, 1'b0, 8'h00, ddps_pkg::DDPS_OP_INC, 16'h0);
    check(dp, 16'h0001, "inc one");
    check(dp0, 16'habcd, "zero kept");
    step(1'b0, 1'b1, 8'h00, ddps_pkg::DDPS_OP_NONE, 16'h0);
    check(dp, 16'habcd, "back to zero");
    $display("swap test done");
  endtask : t_swap
  // Writes to another address leave the register alone
  task automatic t_other;
    @(posedge clk);
    sfr_addr <= 8'h8f;
    sfr_write <= 1'b1;
    sfr_wdata <= 8'h09;
    @(posedge clk);
    sfr_write <= 1'b0;
    #1;
    check(16'({hit, sfr_rdata}), 16'h0, "other address read");
    check(16'({flag, sel}), 16'h0, "other address write");
    @(posedge clk);
    sfr_addr <= 8'ha2;
    $display("other test done");
  endtask : t_other
  // Reset in mid-run clears selector, flag and both pointers
  task automatic t_rerun;
    step(1'b1, 1'b0, 8'h09, ddps_pkg::DDPS_OP_LOAD, 16'h5a5a);
    check(dp0, 16'h5a5a, "load before rerun");
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    check(16'(sfr_rdata & 8'h0d), 16'h0, "aux rerun");
    check(dp0 | dp1, 16'h0, "pointer rerun");
    $display("rerun test done");
  endtask : t_rerun
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_flag;
    t_swap;
    t_other;
    t_rerun;
    test_done;
  end
endmodule : ddps_top_tb
`default_nettype wire
